//--- logic/slc_map.svh
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

`define SLC_DATA_W        16
`define SLC_SFR_TOP       16'h0800
`define SLC_WORD_STEP     16'h0002
`define SLC_SP_RESET      16'h0800
`define SLC_LIMIT_BIT0    0

`endif

//--- logic/slc_pkg.sv
package slc_pkg;
    `include "slc_map.svh"

    typedef logic [15:0] slc_word_t;

    typedef enum logic [1:0] {
        SLC_OP_NONE = 2'b00,
        SLC_OP_PUSH = 2'b01,
        SLC_OP_POP  = 2'b10,
        SLC_OP_EA   = 2'b11
    } slc_op_t;

    typedef enum logic [1:0] {
        SLC_PUSH_DATA = 2'b00,
        SLC_PUSH_CALL = 2'b01,
        SLC_PUSH_EXC  = 2'b10
    } slc_push_t;
endpackage : slc_pkg

//--- logic/slc_bound_check.sv
`timescale 1ns/1ps
`include "slc_map.svh"
module slc_bound_check (
    input  wire logic [15:0] addr,
    input  wire logic [15:0] limit,
    input  wire logic        isPush,
    input  wire logic        check,
    output logic             overflow,
    output logic             underflow
);
    import slc_pkg::*;

    // Push at sp == limit passes; one word beyond traps
    assign overflow  = check && isPush && (addr > limit);
    assign underflow = check && (addr < `SLC_SFR_TOP);
endmodule : slc_bound_check

//--- logic/slc_stack_limit_checker.sv
`timescale 1ns/1ps
// Notes on behaviour
// - stack pointer is also a working register
// - pointer holds next free word, grows up
// - pop predecrements, push post-increments
// - call push clears pushed upper byte
// - exception push puts status low byte high
// - limit register has no reset value
// - limit bit 0 always zero
// - only push addresses checked against limit; pop and EA only against floor
// - push at limit passes, next traps
`include "slc_map.svh"
module slc_stack_limit_checker (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire slc_pkg::slc_op_t  op,
    input  wire slc_pkg::slc_push_t pushKind,
    input  wire logic [15:0]       pushData,
    input  wire logic [15:0]       progCounter,
    input  wire logic [7:0]        status_low_byte,
    input  wire logic [15:0]       eaAddr,
    input  wire logic              spWrite,
    input  wire logic [15:0]       spWriteData,
    input  wire logic              limitWrite,
    input  wire logic [15:0]       limitWriteData,
    output logic [15:0]            stack_pointer_reg,
    output logic [15:0]            stack_limit_reg,
    output logic [15:0]            memAddr,
    output logic [15:0]            memWriteData,
    output logic                   memWrite,
    output logic                   memRead,
    output logic                   stackTrap,
    output logic                   trapOverflow,
    output logic                   trapUnderflow
);
    import slc_pkg::*;

    logic [15:0] checkAddr;
    logic [15:0] pushWord;
    logic        isPush;
    logic        checkNow;
    logic        ovf;
    logic        unf;
    logic [15:0] limitRaw;

    // ------------------------------------------------------------
    // Check address select and pointer update
    // ------------------------------------------------------------
    always_comb begin
        unique case (op)
            SLC_OP_PUSH: checkAddr = stack_pointer_reg;
            SLC_OP_POP:  checkAddr = stack_pointer_reg - `SLC_WORD_STEP;
            SLC_OP_EA:   checkAddr = eaAddr;
            SLC_OP_NONE: checkAddr = stack_pointer_reg;
        endcase
    end

    assign isPush   = (op == SLC_OP_PUSH);
    assign checkNow = (op != SLC_OP_NONE);

    // General register write wins as ordinary working-register use
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stack_pointer_reg <= `SLC_SP_RESET;
        end else if (spWrite) begin
            stack_pointer_reg <= {spWriteData[15:1], 1'b0};
        end else if (op == SLC_OP_PUSH) begin
            stack_pointer_reg <= stack_pointer_reg + `SLC_WORD_STEP;
        end else if (op == SLC_OP_POP) begin
            stack_pointer_reg <= stack_pointer_reg - `SLC_WORD_STEP;
        end
    end

    // ------------------------------------------------------------
    // Limit register
    // ------------------------------------------------------------
    // No reset branch on purpose: contents undefined until written
    always_ff @(posedge sys_clk) begin
        if (limitWrite) begin
            limitRaw <= limitWriteData;
        end
    end

    assign stack_limit_reg = {limitRaw[15:1], 1'b0};

    // ------------------------------------------------------------
    // Pushed word shaping
    // ------------------------------------------------------------
    always_comb begin
        unique case (pushKind)
            SLC_PUSH_CALL: pushWord = {8'h00, progCounter[7:0]};
            SLC_PUSH_EXC:  pushWord = {status_low_byte, progCounter[7:0]};
            default:       pushWord = pushData;
        endcase
    end

    // ------------------------------------------------------------
    // Memory request, registered
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            memAddr      <= 16'h0000;
            memWriteData <= 16'h0000;
            memWrite     <= 1'b0;
            memRead      <= 1'b0;
        end else begin
            memAddr      <= checkAddr;
            memWriteData <= pushWord;
            memWrite     <= isPush;
            memRead      <= (op == SLC_OP_POP);
        end
    end

    // ------------------------------------------------------------
    // Bound check and trap
    // ------------------------------------------------------------
    slc_bound_check u_check (
        .addr      (checkAddr),
        .limit     (stack_limit_reg),
        .isPush    (isPush),
        .check     (checkNow),
        .overflow  (ovf),
        .underflow (unf)
    );

    // Single-cycle pulse in the cycle the address is checked
    assign stackTrap     = ovf | unf;
    assign trapOverflow  = ovf;
    assign trapUnderflow = unf;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_push_inc;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH && !spWrite) |=>
            stack_pointer_reg == $past(stack_pointer_reg) + `SLC_WORD_STEP;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push did not increment");

    property p_pop_dec;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_POP && !spWrite) |=>
            stack_pointer_reg == $past(stack_pointer_reg) - `SLC_WORD_STEP
            && memAddr == stack_pointer_reg && memRead;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop not predecremented");

    property p_push_addr;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH) |=> memWrite && memAddr == $past(stack_pointer_reg);
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("push address wrong");

    property p_call_zero;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH && pushKind == SLC_PUSH_CALL) |=> memWriteData[15:8] == 8'h00;
    endproperty
    a_call_zero: assert property (p_call_zero) else $error("call upper byte set");

    property p_exc_srl;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH && pushKind == SLC_PUSH_EXC) |=>
            memWriteData[15:8] == $past(status_low_byte);
    endproperty
    a_exc_srl: assert property (p_exc_srl) else $error("status byte missing");

    property p_lim_bit0;
        @(posedge sys_clk) disable iff (reset)
        limitWrite |=> stack_limit_reg[0] == 1'b0
            && stack_limit_reg[15:1] == $past(limitWriteData[15:1]);
    endproperty
    a_lim_bit0: assert property (p_lim_bit0) else $error("limit bit 0 set");

    property p_at_limit;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH && stack_pointer_reg == stack_limit_reg
         && stack_pointer_reg >= `SLC_SFR_TOP) |-> !stackTrap;
    endproperty
    a_at_limit: assert property (p_at_limit) else $error("trap at limit");

    property p_beyond;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_PUSH && stack_pointer_reg > stack_limit_reg) |-> stackTrap;
    endproperty
    a_beyond: assert property (p_beyond) else $error("missed overflow");

    property p_under;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_EA && eaAddr < `SLC_SFR_TOP) |-> stackTrap && trapUnderflow;
    endproperty
    a_under: assert property (p_under) else $error("missed underflow");

    property p_pulse;
        @(posedge sys_clk) disable iff (reset)
        stackTrap |-> checkNow;
    endproperty
    a_pulse: assert property (p_pulse) else $error("trap without check");

    // Ordinary register write must land word-aligned, whatever op says
    property p_sp_write;
        @(posedge sys_clk) disable iff (reset)
        spWrite |=> stack_pointer_reg == {$past(spWriteData[15:1]), 1'b0};
    endproperty
    a_sp_write: assert property (p_sp_write) else $error("pointer write lost");

    // Pop from the floor checks the predecremented word, not the pointer
    property p_pop_under;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_POP && stack_pointer_reg == `SLC_SFR_TOP) |->
            stackTrap && trapUnderflow;
    endproperty
    a_pop_under: assert property (p_pop_under) else $error("pop below floor missed");

    property p_idle_quiet;
        @(posedge sys_clk) disable iff (reset)
        (op == SLC_OP_NONE) |-> !trapOverflow && !trapUnderflow;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("trap with no operation");

    c_push: cover property (@(posedge sys_clk) disable iff (reset) op == SLC_OP_PUSH);
    c_pop:  cover property (@(posedge sys_clk) disable iff (reset) op == SLC_OP_POP);
    c_ovf:  cover property (@(posedge sys_clk) disable iff (reset) trapOverflow);
    c_unf:  cover property (@(posedge sys_clk) disable iff (reset) trapUnderflow);
endmodule : slc_stack_limit_checker

//--- sim/slc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Core data memory behind the stack port
// ----------------------------------------
module slc_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWriteData,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    output logic      [15:0] readData
);
    logic [15:0] mem [0:2047];
    // Idle read bus toggles so a stale word never looks valid
    always @(posedge sys_clk) begin
        if (memWrite)
            mem[memAddr[11:1]] <= memWriteData;
        readData <= memRead ? mem[memAddr[11:1]] : ~readData;
    end
endmodule : slc_mem_model

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
    import slc_pkg::*;
    logic             sys_clk, reset, spWrite, limitWrite, memWrite, memRead;
    logic             stackTrap, trapOverflow, trapUnderflow;
    slc_op_t          op;
    slc_push_t        pushKind;
    logic [15:0]      pushData, progCounter, eaAddr, spWriteData, limitWriteData, readData;
    logic [15:0]      stack_pointer_reg, stack_limit_reg, memAddr, memWriteData;
    logic [7:0]       status_low_byte;
    int               failures, checksDone;
    slc_stack_limit_checker dut_u (.sys_clk, .reset, .op, .pushKind, .pushData, .progCounter,
        .status_low_byte, .eaAddr, .spWrite, .spWriteData, .limitWrite, .limitWriteData,
        .stack_pointer_reg, .stack_limit_reg, .memAddr, .memWriteData, .memWrite, .memRead,
        .stackTrap, .trapOverflow, .trapUnderflow);
    slc_mem_model mem_u (.sys_clk, .memAddr, .memWriteData, .memWrite, .memRead, .readData);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic closeOut;
        $display("checks %0d failures %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : closeOut
    // Extra idle cycle keeps stack reads away from a fresh limit write
    task automatic load(input logic [15:0] sp, input logic [15:0] lim);
        {spWrite, limitWrite, spWriteData, limitWriteData} = {2'b11, sp, lim};
        tick();
        {spWrite, limitWrite} = 2'b00;
        tick();
    endtask : load
    // Expected trap given as {overflow, underflow}
    task automatic doOp(input slc_op_t o, input logic [1:0] t, input logic [15:0] a, d);
        op = o;
        #30;
        `CHK("stackTrap", |t, stackTrap)
        `CHK("trapOverflow", t[1], trapOverflow)
        `CHK("trapUnderflow", t[0], trapUnderflow)
        tick();
        op = SLC_OP_NONE;
        if (o != SLC_OP_EA) begin
            `CHK("memAddr", a, memAddr)
            `CHK("memWrite", o == SLC_OP_PUSH, memWrite)
            `CHK("memRead", o == SLC_OP_POP, memRead)
            if (o == SLC_OP_PUSH)
                `CHK("memWriteData", d, memWriteData)
        end
        #30;
        `CHK("trapPulse", 1'b0, stackTrap)
        tick();
    endtask : doOp
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testPushPop;
        `CHK("spReset", 16'h0800, stack_pointer_reg)
        load(16'h0901, 16'h0A05);
        `CHK("spWord", 16'h0900, stack_pointer_reg)
        `CHK("limitBit0", 16'h0A04, stack_limit_reg)
        pushData = 16'h1234;
        doOp(SLC_OP_PUSH, 2'b00, 16'h0900, 16'h1234);
        `CHK("spPush", 16'h0902, stack_pointer_reg)
        doOp(SLC_OP_POP, 2'b00, 16'h0900, 16'h0000);
        `CHK("spPop", 16'h0900, stack_pointer_reg)
        `CHK("popData", 16'h1234, readData)
        progCounter = 16'hABCD;
        status_low_byte = 8'h5A;
        pushKind = SLC_PUSH_CALL;
        doOp(SLC_OP_PUSH, 2'b00, 16'h0900, 16'h00CD);
        pushKind = SLC_PUSH_EXC;
        doOp(SLC_OP_PUSH, 2'b00, 16'h0902, 16'h5ACD);
        pushKind = SLC_PUSH_DATA;
        $display("test pushPop done, failures %0d", failures);
    endtask : testPushPop
    task automatic testBounds;
        load(16'h0A04, 16'h0A04);
        doOp(SLC_OP_PUSH, 2'b00, 16'h0A04, 16'h1234);
        doOp(SLC_OP_PUSH, 2'b10, 16'h0A06, 16'h1234);
        load(16'h0800, 16'h0A04);
        doOp(SLC_OP_POP, 2'b01, 16'h07FE, 16'h0000);
        load(16'h0900, 16'h0A04);
        eaAddr = 16'h07FE;
        doOp(SLC_OP_EA, 2'b01, 16'h0000, 16'h0000);
        eaAddr = 16'h0900;
        doOp(SLC_OP_EA, 2'b00, 16'h0000, 16'h0000);
        $display("test bounds done, failures %0d", failures);
    endtask : testBounds
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #40000;
        failures++;
        closeOut();
    end
    initial begin
        {reset, spWrite, limitWrite} = 3'b100;
        op = SLC_OP_NONE;
        pushKind = SLC_PUSH_DATA;
        {pushData, progCounter, eaAddr, spWriteData, limitWriteData} = '0;
        status_low_byte = 8'h00;
        repeat (4) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        testPushPop();
        testBounds();
        closeOut();
    end
endmodule : tb
